// ===== hdl/sebsf_pkg.sv
// constants, states and variants of the serial eeprom bus slave front end
package sebsf_pkg;

  // system clock and derived timing
  localparam int CLK_FREQ_HZ          = 100_000_000;
  localparam int CLK_FREQ_MHZ         = CLK_FREQ_HZ / 1_000_000;
  // internal nonvolatile write cycle, longest time in ms
  localparam int WRITE_CYCLE_TIME_MS  = 10;
  // longest time rounds down
  localparam int WRITE_CYCLE_CYCLES   =
    WRITE_CYCLE_TIME_MS * (CLK_FREQ_HZ / 1000);
  // bus noise suppression time in ns, longest figure
  localparam int NOISE_TIME_NS        = 50;
  localparam int NOISE_CYCLES_RAW     = NOISE_TIME_NS * CLK_FREQ_MHZ / 1000;
  localparam int NOISE_CYCLES         =
    (NOISE_CYCLES_RAW < 1) ? 1 : NOISE_CYCLES_RAW;

  // byte framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] TX_LAST_BIT   = 4'h7;

  // device address byte layout
  localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
  localparam int         DEV_CODE_MSB  = 7;
  localparam int         DEV_CODE_LSB  = 4;
  localparam int         SEL2_POS      = 3;
  localparam int         SEL1_POS      = 2;
  localparam int         SEL0_POS      = 1;
  localparam int         RW_POS        = 0;

  // byte position inside a transaction
  localparam logic [1:0] BYTE_DEV      = 2'h0;
  localparam logic [1:0] BYTE_WORD     = 2'h1;
  localparam logic [1:0] BYTE_DATA     = 2'h2;

  // density variants
  typedef enum logic [1:0] {
    SEBSF_D1K = 2'h0,
    SEBSF_D2K = 2'h1,
    SEBSF_D4K = 2'h2,
    SEBSF_D8K = 2'h3
  } sebsf_density_t;

  // compare masks for the address-select bits {sel2, sel1, sel0}
  localparam logic [2:0] SEL_MASK_SMALL = 3'h7;
  localparam logic [2:0] SEL_MASK_4K    = 3'h6;
  localparam logic [2:0] SEL_MASK_8K    = 3'h4;

  // slave state machine
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RX   = 6'h02,
    ST_ACK  = 6'h04,
    ST_TX   = 6'h08,
    ST_MACK = 6'h10,
    ST_WAIT = 6'h20
  } sebsf_state_t;

endpackage : sebsf_pkg

// ===== hdl/sebsf_pin_filt.sv
// three-stage synchroniser with glitch filter for one pin
module sebsf_pin_filt #(
  parameter int   FILT_LEN = 5,
  parameter logic RST_VAL  = 1'b1
) (
  // clock and control
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic ce_i,
  // pin and filtered level
  input  wire logic pin_i,
  output logic      level_o
);

  localparam int CW = $clog2(FILT_LEN + 1);

  logic          s1_q;
  logic          s2_q;
  logic          s3_q;
  logic [CW-1:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
    end else if (ce_i) begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a new level must hold agreed for FILT_LEN cycles, so spikes vanish
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_q   <= '0;
      level_o <= RST_VAL;
    end else if (ce_i) begin
      if ((s2_q != s3_q) || (s3_q == level_o)) begin
        cnt_q <= '0;
      end else if (cnt_q == CW'(FILT_LEN - 1)) begin
        cnt_q   <= '0;
        level_o <= s3_q;
      end else begin
        cnt_q <= cnt_q + CW'(1);
      end
    end
  end

endmodule : sebsf_pin_filt

// ===== hdl/sebsf_wr_timer.sv
// internal write cycle timer, busy from launch for a fixed count
module sebsf_wr_timer #(
  parameter int WR_CYCLES = 1000
) (
  // clock and control
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic ce_i,
  // launch pulse and busy level
  input  wire logic launch_i,
  output logic      busy_o
);

  localparam int CW = $clog2(WR_CYCLES + 1);

  logic [CW-1:0] cnt_q;

  // busy lasts exactly WR_CYCLES cycles, the whole longest write time
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_q  <= '0;
      busy_o <= 1'b0;
    end else if (ce_i) begin
      if (launch_i && !busy_o) begin
        cnt_q  <= CW'(WR_CYCLES - 1);
        busy_o <= 1'b1;
      end else if (busy_o) begin
        if (cnt_q == '0) begin
          busy_o <= 1'b0;
        end else begin
          cnt_q <= cnt_q - CW'(1);
        end
      end
    end
  end

endmodule : sebsf_wr_timer

// ===== hdl/sebsf_top.sv
// two-wire serial eeprom slave front end: framing, addressing, ack, write
module sebsf_top
  import sebsf_pkg::*;
#(
  parameter sebsf_density_t DENSITY   = SEBSF_D1K,
  parameter int             WR_CYCLES = WRITE_CYCLE_CYCLES,
  parameter int             FILT_LEN  = NOISE_CYCLES
) (
  // clock, reset, enable
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       ce_i,
  // two-wire bus
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // straps and protection
  input  wire logic       addr_sel_0_i,
  input  wire logic       addr_sel_1_i,
  input  wire logic       addr_sel_2_i,
  input  wire logic       wp_i,
  // memory side, write path
  output logic [7:0]      word_addr_o,
  output logic [1:0]      page_o,
  output logic [7:0]      wr_data_o,
  output logic            wr_valid_o,
  output logic            wr_launch_o,
  output logic            busy_o,
  // memory side, read path
  output logic            rd_req_o,
  input  wire logic [7:0] rd_data_i
);

  localparam logic [2:0] SEL_MASK =
    (DENSITY == SEBSF_D4K) ? SEL_MASK_4K :
    (DENSITY == SEBSF_D8K) ? SEL_MASK_8K : SEL_MASK_SMALL;

  // filtered pin levels, and the raw strap bundle
  logic         scl_f;
  logic         sda_f;
  logic [3:0]   strap_f;
  logic [3:0]   strap_raw;

  // edge history and bus events
  logic         scl_q;
  logic         sda_q;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_ev;
  logic         stop_ev;

  // transaction state
  sebsf_state_t state_q;
  logic [3:0]   bitcnt_q;
  logic [7:0]   shreg_q;
  logic [1:0]   byte_idx_q;
  logic         rw_q;
  logic         wr_any_q;
  logic         ack_q;
  logic [7:0]   tx_q;
  logic         mack_q;
  logic         rd_take;
  logic         addr_match;
  logic         wp_f;

  sebsf_pin_filt #(
    .FILT_LEN (FILT_LEN),
    .RST_VAL  (1'b1)
  ) u_scl_filt (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .ce_i    (ce_i),
    .pin_i   (scl_i),
    .level_o (scl_f)
  );

  sebsf_pin_filt #(
    .FILT_LEN (FILT_LEN),
    .RST_VAL  (1'b1)
  ) u_sda_filt (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .ce_i    (ce_i),
    .pin_i   (sda_i),
    .level_o (sda_f)
  );

  // straps and write protect are pins too, so they go through the filter
  assign strap_raw = {wp_i, addr_sel_2_i, addr_sel_1_i, addr_sel_0_i};

  for (genvar g = 0; g < 4; g++) begin : g_strap
    sebsf_pin_filt #(
      .FILT_LEN (FILT_LEN),
      .RST_VAL  (1'b0)
    ) u_strap_filt (
      .clk_i   (clk_i),
      .srst_i  (srst_i),
      .ce_i    (ce_i),
      .pin_i   (strap_raw[g]),
      .level_o (strap_f[g])
    );
  end

  assign wp_f = strap_f[3];

  sebsf_wr_timer #(
    .WR_CYCLES (WR_CYCLES)
  ) u_wr_timer (
    .clk_i    (clk_i),
    .srst_i   (srst_i),
    .ce_i     (ce_i),
    .launch_i (wr_launch_o),
    .busy_o   (busy_o)
  );

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce_i) begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  assign scl_rise = ce_i & scl_f & ~scl_q;
  assign scl_fall = ce_i & ~scl_f & scl_q;
  assign start_ev = ce_i & scl_f & scl_q & sda_q & ~sda_f;
  assign stop_ev  = ce_i & scl_f & scl_q & ~sda_q & sda_f;

  // device code, then masked select bits against the straps
  assign addr_match =
    (shreg_q[DEV_CODE_MSB:DEV_CODE_LSB] == DEV_TYPE_CODE) &&
    ((({shreg_q[SEL2_POS], shreg_q[SEL1_POS], shreg_q[SEL0_POS]} ^
       strap_f[2:0]) & SEL_MASK) == 3'h0) &&
    !busy_o;

  // data is taken from the array at the fall that starts each read byte
  assign rd_take = scl_fall & !stop_ev & !start_ev &
    (((state_q == ST_ACK) && rw_q) || ((state_q == ST_MACK) && mack_q));
  assign rd_req_o = rd_take;

  // open drain: the output level is always low, only the enable moves
  assign sda_o    = 1'b0;
  assign sda_oe_o = ack_q | ((state_q == ST_TX) & ~tx_q[7]);

  // stop during a write with received data launches the nonvolatile cycle
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_launch_o <= 1'b0;
    end else if (ce_i) begin
      wr_launch_o <= stop_ev && !rw_q && wr_any_q && !wp_f &&
        (byte_idx_q == BYTE_DATA) &&
        ((state_q == ST_RX) || (state_q == ST_ACK));
    end
  end

  // data bytes reach the array only while unprotected
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_valid_o <= 1'b0;
      wr_data_o  <= 8'h00;
    end else if (ce_i) begin
      wr_valid_o <= 1'b0;
      if ((state_q == ST_RX) && scl_fall && !stop_ev && !start_ev &&
          (bitcnt_q == BITS_PER_BYTE) && (byte_idx_q == BYTE_DATA) &&
          !wp_f) begin
        wr_valid_o <= 1'b1;
        wr_data_o  <= shreg_q;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q     <= ST_IDLE;
      bitcnt_q    <= 4'h0;
      shreg_q     <= 8'h00;
      byte_idx_q  <= BYTE_DEV;
      rw_q        <= 1'b0;
      wr_any_q    <= 1'b0;
      ack_q       <= 1'b0;
      tx_q        <= 8'hff;
      mack_q      <= 1'b0;
      word_addr_o <= 8'h00;
      page_o      <= 2'h0;
    end else if (ce_i) begin
      if (stop_ev) begin
        // read aborts, write ends intake; either way back to standby
        state_q  <= ST_IDLE;
        ack_q    <= 1'b0;
        wr_any_q <= 1'b0;
      end else if (start_ev) begin
        ack_q    <= 1'b0;
        wr_any_q <= 1'b0;
        if (busy_o) begin
          state_q <= ST_IDLE;
        end else begin
          state_q    <= ST_RX;
          bitcnt_q   <= 4'h0;
          byte_idx_q <= BYTE_DEV;
        end
      end else begin
        case (state_q)
          ST_IDLE: begin
            ack_q <= 1'b0;
          end
          ST_RX: begin
            if (scl_rise) begin
              shreg_q  <= {shreg_q[6:0], sda_f};
              bitcnt_q <= bitcnt_q + 4'h1;
            end else if (scl_fall && (bitcnt_q == BITS_PER_BYTE)) begin
              bitcnt_q <= 4'h0;
              if (byte_idx_q == BYTE_DEV) begin
                if (addr_match) begin
                  ack_q   <= 1'b1;
                  rw_q    <= shreg_q[RW_POS];
                  page_o  <= {shreg_q[SEL1_POS], shreg_q[SEL0_POS]};
                  state_q <= ST_ACK;
                end else begin
                  state_q <= ST_IDLE;
                end
              end else begin
                if (byte_idx_q == BYTE_WORD) begin
                  word_addr_o <= shreg_q;
                end else begin
                  wr_any_q <= wr_any_q | !wp_f;
                end
                ack_q   <= 1'b1;
                state_q <= ST_ACK;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              ack_q    <= 1'b0;
              bitcnt_q <= 4'h0;
              if (byte_idx_q != BYTE_DATA) begin
                byte_idx_q <= byte_idx_q + 2'h1;
              end
              if (rw_q) begin
                tx_q    <= rd_data_i;
                state_q <= ST_TX;
              end else begin
                state_q <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bitcnt_q == TX_LAST_BIT) begin
                bitcnt_q <= 4'h0;
                tx_q     <= 8'hff;
                state_q  <= ST_MACK;
              end else begin
                bitcnt_q <= bitcnt_q + 4'h1;
                tx_q     <= {tx_q[6:0], 1'b1};
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              mack_q <= ~sda_f;
            end else if (scl_fall) begin
              if (mack_q) begin
                tx_q    <= rd_data_i;
                state_q <= ST_TX;
              end else begin
                state_q <= ST_WAIT;
              end
            end
          end
          ST_WAIT: begin
            ack_q <= 1'b0;
          end
          default: begin
            state_q <= ST_IDLE;
            ack_q   <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule : sebsf_top

// ===== tb/sebsf_chk.sv
// assertion checker for the two-wire slave front end
module sebsf_chk #(
  parameter int WR_CYCLES = 50
) (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       srst_i,
  // bus and protection
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic       wp_i,
  // memory side
  input wire logic       wr_valid_o,
  input wire logic       wr_launch_o,
  input wire logic       busy_o,
  input wire logic       rd_req_o,
  input wire logic [7:0] rd_data_i
);
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  // busy cycles so far, cleared whenever busy is low
  int busy_cnt_q;
  always_ff @(posedge clk_i) begin
    if (srst_i || !busy_o) busy_cnt_q <= 0;
    else busy_cnt_q <= busy_cnt_q + 1;
  end

  property p_sda_low;
    sda_o == 1'b0;
  endproperty
  property p_oe_scl;
    $changed(sda_oe_o) |-> !scl_i;
  endproperty
  property p_rd_bit;
    rd_req_o |=> sda_oe_o == !$past(rd_data_i[7]);
  endproperty
  property p_ack_valid;
    wr_valid_o |-> sda_oe_o ##1 !wr_valid_o;
  endproperty
  property p_launch;
    wr_launch_o |=> busy_o && !wr_launch_o;
  endproperty
  property p_stop_launch;
    wr_launch_o |-> scl_i && sda_i;
  endproperty
  property p_busy_quiet;
    busy_o |-> !sda_oe_o && !rd_req_o && !wr_valid_o;
  endproperty
  // eight cycles covers the pin filter latency of the protect input
  property p_wp;
    wp_i [*8] |-> !wr_valid_o && !wr_launch_o;
  endproperty
  property p_busy_len;
    busy_o |-> busy_cnt_q < WR_CYCLES;
  endproperty
  property p_busy_end;
    $fell(busy_o) |-> busy_cnt_q == WR_CYCLES;
  endproperty

  a_sda_low: assert property (p_sda_low) else $error("sda out not low");
  a_oe_scl: assert property (p_oe_scl) else $error("sda moved, scl high");
  a_rd_bit: assert property (p_rd_bit) else $error("first read bit wrong");
  a_ack_valid: assert property (p_ack_valid) else $error("no byte ack");
  a_launch: assert property (p_launch) else $error("launch not busy");
  a_stop_launch: assert property (p_stop_launch) else $error("no stop");
  a_busy_quiet: assert property (p_busy_quiet) else $error("busy active");
  a_wp: assert property (p_wp) else $error("write while protected");
  a_busy_len: assert property (p_busy_len) else $error("busy too long");
  a_busy_end: assert property (p_busy_end) else $error("busy length");

  c_launch: cover property (wr_launch_o);
  c_read: cover property (rd_req_o);
  c_busy_end: cover property ($fell(busy_o));
endmodule : sebsf_chk

bind sebsf_top sebsf_chk #(.WR_CYCLES(WR_CYCLES)) sebsf_chk_inst (
  .clk_i(clk_i), .srst_i(srst_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .wp_i(wp_i),
  .wr_valid_o(wr_valid_o), .wr_launch_o(wr_launch_o), .busy_o(busy_o),
  .rd_req_o(rd_req_o), .rd_data_i(rd_data_i));

// ===== tb/sebsf_master.sv
// two-wire bus master model, clock and open-drain data
module sebsf_master (
  // clock
  input  wire logic clk_i,
  // bus
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // clock stands high and data released between frames
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
  end

  // quarter of a 160 ns bus period
  task automatic q();
    repeat (4) @(negedge clk_i);
  endtask : q

  // low phase of 8 clocks leaves room for the slave's filter lag
  task automatic bit_x(input logic b, output logic r);
    q();
    sda_oe_o = ~b;
    q();
    scl_o = 1'b1;
    q();
    r = sda_i;
    q();
    scl_o = 1'b0;
  endtask : bit_x

  task automatic start();
    q();
    sda_oe_o = 1'b0;
    q();
    scl_o = 1'b1;
    q();
    sda_oe_o = 1'b1;
    q();
    scl_o = 1'b0;
  endtask : start

  task automatic stop();
    q();
    sda_oe_o = 1'b1;
    q();
    scl_o = 1'b1;
    q();
    sda_oe_o = 1'b0;
    q();
  endtask : stop

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask : wbyte

  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(~mack, r);
  endtask : rbyte
endmodule : sebsf_master

// ===== tb/sebsf_top_tb.sv
// self-checking bench for the two-wire slave front end
module sebsf_top_tb
  import sebsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int WR = 50;
  logic       clk_i, srst_i, scl, m_oe, sda_oe, sda_o, wp;
  logic       ce, ce8, sda_oe8;
  logic       wr_valid, wr_launch, busy, rd_req;
  logic [2:0] sel;
  logic [1:0] page, page8;
  logic [7:0] word_addr, wr_data, rd_data;
  int         err_count, checked, vcnt, lcnt, bcnt;
  // pulled-up data wire, low while the master or either slave pulls it
  wire        sda = ~(m_oe | sda_oe | sda_oe8);

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  sebsf_top #(.DENSITY(SEBSF_D4K), .WR_CYCLES(WR), .FILT_LEN(2))
  sebsf_top_inst (
    .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_sel_0_i(sel[0]),
    .addr_sel_1_i(sel[1]), .addr_sel_2_i(sel[2]), .wp_i(wp),
    .word_addr_o(word_addr), .page_o(page), .wr_data_o(wr_data),
    .wr_valid_o(wr_valid), .wr_launch_o(wr_launch), .busy_o(busy),
    .rd_req_o(rd_req), .rd_data_i(rd_data));

  // 8-kbit twin on the same wire, frozen unless its own test runs;
  // its top strap is inverted so it owns the other half of the addresses
  sebsf_top #(.DENSITY(SEBSF_D8K), .WR_CYCLES(WR), .FILT_LEN(2))
  sebsf_top_d8k_inst (
    .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce8), .scl_i(scl), .sda_i(sda),
    .sda_o(), .sda_oe_o(sda_oe8), .addr_sel_0_i(sel[0]),
    .addr_sel_1_i(sel[1]), .addr_sel_2_i(~sel[2]), .wp_i(wp),
    .word_addr_o(), .page_o(page8), .wr_data_o(), .wr_valid_o(),
    .wr_launch_o(), .busy_o(), .rd_req_o(), .rd_data_i(rd_data));

  sebsf_master sebsf_master_inst (
    .clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(m_oe));

  always @(posedge clk_i) begin
    vcnt += int'(wr_valid === 1'b1);
    lcnt += int'(wr_launch === 1'b1);
    bcnt += int'(busy === 1'b1);
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  task automatic wb(input logic [7:0] d, input logic exp);
    logic a;
    sebsf_master_inst.wbyte(d, a);
    chk({7'h0, a}, {7'h0, exp});
  endtask : wb

  // straps are 101: the 4-kbit variant ignores select bit 0
  task automatic t_addr();
    logic [7:0] dev [5] = '{8'ha8, 8'haa, 8'hac, 8'ha0, 8'hb8};
    logic       ack [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    for (int i = 0; i < 5; i++) begin
      sebsf_master_inst.start();
      wb(dev[i], ack[i]);
      sebsf_master_inst.stop();
    end
    $display("address test done");
  endtask : t_addr

  task automatic t_write();
    vcnt = 0;
    lcnt = 0;
    bcnt = 0;
    sebsf_master_inst.start();
    wb(8'haa, 1'b1);
    wb(8'h3c, 1'b1);
    chk(word_addr, 8'h3c);
    chk({6'h0, page}, 8'h01);
    wb(8'h5a, 1'b1);
    wb(8'hc3, 1'b1);
    chk(wr_data, 8'hc3);
    chk(8'(vcnt), 8'h02);
    sebsf_master_inst.stop();
    repeat (8) @(negedge clk_i);
    chk(8'(lcnt), 8'h01);
    chk({7'h0, busy}, 8'h01);
    // address poll lands inside the write cycle and must go unanswered
    sebsf_master_inst.start();
    wb(8'ha9, 1'b0);
    sebsf_master_inst.stop();
    for (int i = 0; i < 200 && busy !== 1'b0; i++) @(negedge clk_i);
    chk(8'(bcnt), 8'(WR));
    $display("write test done");
  endtask : t_write

  task automatic t_wp();
    wp = 1'b1;
    vcnt = 0;
    lcnt = 0;
    sebsf_master_inst.start();
    wb(8'ha8, 1'b1);
    wb(8'h10, 1'b1);
    wb(8'h77, 1'b1);
    sebsf_master_inst.stop();
    repeat (20) @(negedge clk_i);
    chk(8'(vcnt), 8'h00);
    chk(8'(lcnt), 8'h00);
    wp = 1'b0;
    $display("protect test done");
  endtask : t_wp

  // stop right after a master ack, while the next byte is under way
  task automatic t_read();
    logic [7:0] d;
    rd_data = 8'h96;
    sebsf_master_inst.start();
    wb(8'ha9, 1'b1);
    sebsf_master_inst.rbyte(1'b1, d);
    chk(d, 8'h96);
    sebsf_master_inst.stop();
    // let the stop pass the filter before looking
    repeat (8) @(negedge clk_i);
    chk({7'h0, sda_oe}, 8'h00);
    chk({7'h0, busy}, 8'h00);
    sebsf_master_inst.start();
    wb(8'ha8, 1'b1);
    sebsf_master_inst.stop();
    $display("read test done");
  endtask : t_read

  // main slave frozen by its enable, so only the 8-kbit twin can answer
  task automatic t_d8k();
    logic [7:0] dev [4] = '{8'ha0, 8'ha6, 8'ha8, 8'hb0};
    logic       ack [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    repeat (10) @(negedge clk_i);
    ce  = 1'b0;
    ce8 = 1'b1;
    repeat (10) @(negedge clk_i);
    for (int i = 0; i < 4; i++) begin
      sebsf_master_inst.start();
      wb(dev[i], ack[i]);
      sebsf_master_inst.stop();
    end
    chk({6'h0, page8}, 8'h03);
    repeat (10) @(negedge clk_i);
    ce8 = 1'b0;
    ce  = 1'b1;
    repeat (10) @(negedge clk_i);
    $display("8-kbit test done");
  endtask : t_d8k

  initial begin
    srst_i = 1'b1;
    ce = 1'b1;
    ce8 = 1'b0;
    wp = 1'b0;
    sel = 3'h5;
    rd_data = 8'h00;
    repeat (5) @(negedge clk_i);
    srst_i = 1'b0;
    repeat (10) @(negedge clk_i);
    t_addr();
    t_write();
    t_wp();
    t_read();
    t_d8k();
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    wrap_up();
  end
endmodule : sebsf_top_tb
